//--- src/apdc_top.sv
// Summary of operation
// - An 8-bit phase register sets delay between right and left outputs.
// - Right delay is fine bits plus middle bits times ADC_OVERSAMPLING_RATIO times filter factor.
// - Filter factor is a quarter for A, half for B, one for C.
// - Left output waits one modulator tick when the top delay bit is set.
// - Two enable bits turn on DC measurement per channel.
// - Each DC result is 24 bits, two integer and 22 fraction bits.
// - Left result occupies three byte registers, right result the next three.
// - Software sets latch to copy results, then clears it after reading.
// - Mode bit 0 selects averaging with length set from 1 to 20.
// - Mode bit 1 selects first-order IIR; higher setting gives narrower bandwidth.
// - Periodic reset clears averaging every 2^R modulator ticks when enabled.
// - A six-bit field selects coupling capacitor fast-charge modes.
// - Anti-thump stays off after reset until its six-bit field is written.
// - Without adaptive mode, coefficients are locked while the ADC runs.
// - Adaptive bit enables double-buffered coefficients in banks A and B.
// - Swap request exchanges banks at next sample start, then self-clears.
// - Bank flag toggles per swap: 0 means A active, 1 means B.
// - While running, coefficient writes go to the idle bank regardless of address.
// - Sample rate is clock over two dividers (1 to 128) and ADC_OVERSAMPLING_RATIO.
//
// Chosen here: register access over Avalon-MM.
`include "apdc_defs.svh"
`default_nettype none
module apdc_top #(
   parameter int SAMPLE_W   = 32,
   parameter int DC_W       = 24,
   parameter int COEF_W     = 24,
   parameter int COEF_DEPTH = 64
) (
   // Clock, reset, enable
   input  wire logic                          mclk,
   input  wire logic                          sys_rst,
   input  wire logic                          clk_en,
   // Avalon-MM slave
   input  wire logic [9:0]                    avs_address,
   input  wire logic                          avs_read,
   input  wire logic                          avs_write,
   input  wire logic [31:0]                   avs_writedata,
   input  wire logic [3:0]                    avs_byteenable,
   output logic      [31:0]                   avs_readdata,
   output logic                               avs_waitrequest,
   // ADC engine side
   input  wire logic                          adc_running,
   input  wire logic [SAMPLE_W-1:0]           adc_left_in,
   input  wire logic [SAMPLE_W-1:0]           adc_right_in,
   output logic                               adc_modulator_clock_en,
   output logic                               adc_sample_rate_tick,
   // Phase-compensated outputs
   output logic      [SAMPLE_W-1:0]           left_out,
   output logic                               left_out_valid,
   output logic      [SAMPLE_W-1:0]           right_out,
   output logic                               right_out_valid,
   // Coefficient read port for the filter engine
   input  wire logic [$clog2(COEF_DEPTH)-1:0] coef_rd_addr,
   output logic      [COEF_W-1:0]             coef_rd_data,
   output logic                               coef_bank,
   // Analog controls
   output logic      [5:0]                    anti_thump_en,
   output logic      [5:0]                    fast_charge_mode
);
   localparam int AW = $clog2(COEF_DEPTH);
   localparam int NS = `APDC_PD_SLOTS;

   if (COEF_DEPTH < 2 || COEF_DEPTH > 64 || (1 << AW) != COEF_DEPTH ||
       COEF_W > 32 || SAMPLE_W < DC_W) begin : g_bad_param
      $error("apdc_top: unsupported parameter values");
   end

   function automatic logic [7:0] div_val(input logic [7:0] f);
      div_val = (f[6:0] == 7'h00) ? `APDC_DIV_ZERO : {1'h0, f[6:0]};
   endfunction

   function automatic logic [7:0] rb_byte(input logic [DC_W-1:0] v, input logic [1:0] k);
      logic [23:0] w;
      w = 24'(v);
      rb_byte = (k == 2'h0) ? w[23:16] : (k == 2'h1) ? w[15:8] : w[7:0];
   endfunction

   // Register state
   logic [7:0] thump_q, fchg_q, phase_q, dccfg_q, dcctl_q;
   logic [7:0] ndiv_q, mdiv_q, adc_oversampling_ratio_q, filt_q;
   logic       adapt_en_q, swap_q, flag_q;
   logic       ack_q;
   logic [31:0] rdata_q;

   // Bus decode
   logic [7:0] idx;
   logic       req, wr_go, is_coef, coef_ok, coef_lock, wr_bank;
   logic [31:0] rd_d;

   assign idx             = avs_address[9:`APDC_IDX_LSB];
   assign req             = avs_read || avs_write;
   // One wait cycle; the write lands on the edge the master sees waitrequest low
   assign avs_waitrequest = req && !ack_q;
   assign avs_readdata    = rdata_q;
   assign wr_go           = clk_en && avs_write && ack_q && avs_byteenable[0];
   assign is_coef         = idx[`APDC_IDX_COEF_BIT];
   assign coef_ok         = {1'h0, idx[5:0]} < 7'(COEF_DEPTH);
   assign coef_lock       = adc_running && !adapt_en_q;
   assign wr_bank         = adc_running ? ~flag_q : idx[`APDC_IDX_BANK_BIT];

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ack_q <= 1'h0;
      end else if (clk_en) begin
         ack_q <= req && !ack_q;
      end
   end

   // Plain control registers
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         thump_q <= `APDC_REG_RST;
         fchg_q  <= `APDC_REG_RST;
         phase_q <= `APDC_REG_RST;
         dccfg_q <= `APDC_REG_RST;
         dcctl_q <= `APDC_REG_RST;
         ndiv_q  <= `APDC_DIV_RST;
         mdiv_q  <= `APDC_DIV_RST;
         adc_oversampling_ratio_q  <= `APDC_ADC_OVERSAMPLING_RATIO_RST;
         filt_q  <= `APDC_REG_RST;
      end else if (wr_go && !is_coef) begin
         case (idx)
            `APDC_IDX_THUMP: thump_q <= avs_writedata[7:0] & `APDC_THUMP_MASK;
            `APDC_IDX_FCHG:  fchg_q  <= avs_writedata[7:0] & `APDC_FCHG_MASK;
            `APDC_IDX_PHASE: phase_q <= avs_writedata[7:0];
            `APDC_IDX_DCCFG: dccfg_q <= avs_writedata[7:0];
            `APDC_IDX_DCCTL: dcctl_q <= avs_writedata[7:0] & `APDC_DCCTL_MASK;
            `APDC_IDX_NDIV:  ndiv_q  <= avs_writedata[7:0] & `APDC_DIV_MASK;
            `APDC_IDX_MDIV:  mdiv_q  <= avs_writedata[7:0] & `APDC_DIV_MASK;
            `APDC_IDX_ADC_OVERSAMPLING_RATIO:  adc_oversampling_ratio_q  <= avs_writedata[7:0];
            `APDC_IDX_FILT:  filt_q  <= avs_writedata[7:0] & `APDC_FILT_MASK;
            default: ;
         endcase
      end
   end

   assign anti_thump_en    = thump_q[`APDC_THUMP_HI:`APDC_THUMP_LO];
   assign fast_charge_mode = fchg_q[`APDC_FCHG_HI:0];

   // Clock dividers: codec clock -> modulator tick -> sample tick
   logic [7:0] nd_cnt_q, md_cnt_q, n_v, m_v;
   logic [8:0] os_cnt_q, adc_oversampling_ratio_v;
   logic       n_wrap, mod_tick, fs_tick;

   assign n_v      = div_val(ndiv_q);
   assign m_v      = div_val(mdiv_q);
   assign adc_oversampling_ratio_v   = (adc_oversampling_ratio_q == 8'h00) ? `APDC_ADC_OVERSAMPLING_RATIO_ZERO : {1'h0, adc_oversampling_ratio_q};
   // Compare with >= so a divider shrunk mid-count cannot run away
   assign n_wrap   = nd_cnt_q >= (n_v - 8'h01);
   assign mod_tick = clk_en && n_wrap && (md_cnt_q >= (m_v - 8'h01));
   assign fs_tick  = mod_tick && (os_cnt_q >= (adc_oversampling_ratio_v - 9'h001));
   assign adc_modulator_clock_en = mod_tick;
   assign adc_sample_rate_tick   = fs_tick;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         nd_cnt_q <= 8'h00;
         md_cnt_q <= 8'h00;
         os_cnt_q <= 9'h000;
      end else if (clk_en) begin
         nd_cnt_q <= n_wrap ? 8'h00 : nd_cnt_q + 8'h01;
         if (n_wrap) begin
            md_cnt_q <= mod_tick ? 8'h00 : md_cnt_q + 8'h01;
         end
         if (mod_tick) begin
            os_cnt_q <= fs_tick ? 9'h000 : os_cnt_q + 9'h001;
         end
      end
   end

   // Double-buffered coefficients
   logic [COEF_W-1:0] coef_mem [0:2*COEF_DEPTH-1];
   logic [COEF_W-1:0] coef_rd_q;
   logic              swap_go;

   assign swap_go      = swap_q && fs_tick && adc_running && adapt_en_q;
   assign coef_bank    = flag_q;
   assign coef_rd_data = coef_rd_q;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         adapt_en_q <= 1'h0;
         swap_q     <= 1'h0;
         flag_q     <= 1'h0;
      end else if (clk_en) begin
         if (swap_go) begin
            flag_q <= ~flag_q;
         end
         // A new request in the swap cycle survives the self-clear
         if (wr_go && !is_coef && idx == `APDC_IDX_ADAPT) begin
            adapt_en_q <= avs_writedata[`APDC_ADP_EN];
            swap_q     <= avs_writedata[`APDC_ADP_SWAP] || (swap_q && !swap_go);
         end else begin
            swap_q <= swap_q && !swap_go;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (wr_go && is_coef && coef_ok && !coef_lock) begin
         coef_mem[{wr_bank, idx[AW-1:0]}] <= avs_writedata[COEF_W-1:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         coef_rd_q <= '0;
      end else if (clk_en) begin
         coef_rd_q <= coef_mem[{flag_q, coef_rd_addr}];
      end
   end

   // DC measurement
   apdc_dc_if dc_cfg ();
   logic [DC_W-1:0] dc_res [2];
   logic [DC_W-1:0] rb_q   [2];
   logic            latch_prev_q;

   assign dc_cfg.mod_tick = mod_tick;
   assign dc_cfg.mode     = apdc_pkg::apdc_dcmode_t'(dccfg_q[`APDC_DC_MODE]);
   assign dc_cfg.len      = dccfg_q[`APDC_DC_LEN_HI:0];
   assign dc_cfg.prst_en  = dcctl_q[`APDC_DCC_PRST];
   assign dc_cfg.prst_exp = dcctl_q[`APDC_DCC_EXP_HI:0];

   apdc_dc_filter #(.IN_W(SAMPLE_W), .DC_W(DC_W)) u_dc_left (
      .mclk         (mclk),
      .sys_rst      (sys_rst),
      .clk_en       (clk_en),
      .cfg          (dc_cfg),
      .enable       (dccfg_q[`APDC_DC_EN_L]),
      .sample_valid (fs_tick),
      .sample       (adc_left_in),
      .result       (dc_res[0])
   );

   apdc_dc_filter #(.IN_W(SAMPLE_W), .DC_W(DC_W)) u_dc_right (
      .mclk         (mclk),
      .sys_rst      (sys_rst),
      .clk_en       (clk_en),
      .cfg          (dc_cfg),
      .enable       (dccfg_q[`APDC_DC_EN_R]),
      .sample_valid (fs_tick),
      .sample       (adc_right_in),
      .result       (dc_res[1])
   );

   // Copy only on the rising latch edge, so a held latch keeps bytes coherent
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         latch_prev_q <= 1'h0;
         rb_q[0]      <= '0;
         rb_q[1]      <= '0;
      end else if (clk_en) begin
         latch_prev_q <= dcctl_q[`APDC_DCC_LATCH];
         if (dcctl_q[`APDC_DCC_LATCH] && !latch_prev_q) begin
            rb_q[0] <= dc_res[0];
            rb_q[1] <= dc_res[1];
         end
      end
   end

   // Read path
   always_comb begin
      rd_d = 32'h0000_0000;
      if (is_coef) begin
         if (coef_ok && !coef_lock) begin
            rd_d = 32'(coef_mem[{idx[`APDC_IDX_BANK_BIT], idx[AW-1:0]}]);
         end
      end else begin
         case (idx)
            `APDC_IDX_ADAPT: rd_d = 32'({adapt_en_q, flag_q, swap_q});
            `APDC_IDX_THUMP: rd_d = 32'(thump_q);
            `APDC_IDX_FCHG:  rd_d = 32'(fchg_q);
            `APDC_IDX_PHASE: rd_d = 32'(phase_q);
            `APDC_IDX_DCCFG: rd_d = 32'(dccfg_q);
            `APDC_IDX_DCCTL: rd_d = 32'(dcctl_q);
            `APDC_IDX_DCL0:          rd_d = 32'(rb_byte(rb_q[0], 2'h0));
            `APDC_IDX_DCL0 + 8'h01:  rd_d = 32'(rb_byte(rb_q[0], 2'h1));
            `APDC_IDX_DCL0 + 8'h02:  rd_d = 32'(rb_byte(rb_q[0], 2'h2));
            `APDC_IDX_DCR0:          rd_d = 32'(rb_byte(rb_q[1], 2'h0));
            `APDC_IDX_DCR0 + 8'h01:  rd_d = 32'(rb_byte(rb_q[1], 2'h1));
            `APDC_IDX_DCR0 + 8'h02:  rd_d = 32'(rb_byte(rb_q[1], 2'h2));
            `APDC_IDX_NDIV:  rd_d = 32'(ndiv_q);
            `APDC_IDX_MDIV:  rd_d = 32'(mdiv_q);
            `APDC_IDX_ADC_OVERSAMPLING_RATIO:  rd_d = 32'(adc_oversampling_ratio_q);
            `APDC_IDX_FILT:  rd_d = 32'(filt_q);
            default:         rd_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rdata_q <= 32'h0000_0000;
      end else if (clk_en && avs_read && !ack_q) begin
         rdata_q <= rd_d;
      end
   end

   // Phase compensation: each sample waits in a slot for its delay in modulator ticks
   logic [8:0]          ka;
   logic [15:0]         t_ch    [2];
   logic [15:0]         pd_cnt_q [2][NS];
   logic                pd_vld_q [2][NS];
   logic [SAMPLE_W-1:0] pd_dat_q [2][NS];
   logic [1:0]          wr_q    [2];
   logic                emit_hit [2];
   logic [1:0]          emit_idx [2];
   logic [SAMPLE_W-1:0] out_q   [2];
   logic                out_vld_q [2];
   logic [SAMPLE_W-1:0] smp     [2];

   assign smp[0] = adc_left_in;
   assign smp[1] = adc_right_in;

   always_comb begin
      unique case (apdc_pkg::apdc_filt_t'(filt_q[`APDC_FILT_HI:0]))
         apdc_pkg::APDC_FILT_A: ka = {2'h0, adc_oversampling_ratio_v[8:2]};
         apdc_pkg::APDC_FILT_B: ka = {1'h0, adc_oversampling_ratio_v[8:1]};
         apdc_pkg::APDC_FILT_C: ka = adc_oversampling_ratio_v;
         default:               ka = adc_oversampling_ratio_v;
      endcase
      t_ch[0] = {15'h0000, phase_q[`APDC_PH_LEFT]};
      t_ch[1] = {11'h000, phase_q[`APDC_PH_FINE_HI:0]} +
                ({14'h0000, phase_q[`APDC_PH_MID_HI:`APDC_PH_MID_LO]} * {7'h00, ka});
   end

   always_comb begin
      for (int c = 0; c < 2; c++) begin
         emit_hit[c] = 1'h0;
         emit_idx[c] = 2'h0;
         for (int e = NS - 1; e >= 0; e--) begin
            if (pd_vld_q[c][e] && pd_cnt_q[c][e] == 16'h0000) begin
               emit_hit[c] = 1'h1;
               emit_idx[c] = 2'(e);
            end
         end
      end
   end

   // Four slots cover a right delay up to three sample periods plus the fine part
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         for (int c = 0; c < 2; c++) begin
            wr_q[c]      <= 2'h0;
            out_q[c]     <= '0;
            out_vld_q[c] <= 1'h0;
            for (int e = 0; e < NS; e++) begin
               pd_cnt_q[c][e] <= 16'h0000;
               pd_vld_q[c][e] <= 1'h0;
               pd_dat_q[c][e] <= '0;
            end
         end
      end else if (clk_en) begin
         for (int c = 0; c < 2; c++) begin
            out_vld_q[c] <= emit_hit[c];
            if (emit_hit[c]) begin
               out_q[c] <= pd_dat_q[c][emit_idx[c]];
            end
            if (fs_tick) begin
               wr_q[c] <= wr_q[c] + 2'h1;
            end
            for (int e = 0; e < NS; e++) begin
               if (fs_tick && wr_q[c] == 2'(e)) begin
                  pd_cnt_q[c][e] <= t_ch[c];
                  pd_vld_q[c][e] <= 1'h1;
                  pd_dat_q[c][e] <= smp[c];
               end else if (emit_hit[c] && emit_idx[c] == 2'(e)) begin
                  pd_vld_q[c][e] <= 1'h0;
               end else if (mod_tick && pd_vld_q[c][e] && pd_cnt_q[c][e] != 16'h0000) begin
                  pd_cnt_q[c][e] <= pd_cnt_q[c][e] - 16'h0001;
               end
            end
         end
      end
   end

   assign left_out        = out_q[0];
   assign left_out_valid  = out_vld_q[0];
   assign right_out       = out_q[1];
   assign right_out_valid = out_vld_q[1];
endmodule
`default_nettype wire

//--- src/apdc_defs.svh
`ifndef APDC_DEFS_SVH
`define APDC_DEFS_SVH

// Register indices; the byte address on the bus is four times the index
`define APDC_IDX_ADAPT     8'h01
`define APDC_IDX_THUMP     8'h3A
`define APDC_IDX_FCHG      8'h47
`define APDC_IDX_PHASE     8'h55
`define APDC_IDX_DCCFG     8'h66
`define APDC_IDX_DCCTL     8'h67
`define APDC_IDX_DCL0      8'h68
`define APDC_IDX_DCR0      8'h6B
`define APDC_IDX_NDIV      8'h70
`define APDC_IDX_MDIV      8'h71
`define APDC_IDX_ADC_OVERSAMPLING_RATIO      8'h72
`define APDC_IDX_FILT      8'h73
`define APDC_IDX_LSB       2
`define APDC_IDX_COEF_BIT  7
`define APDC_IDX_BANK_BIT  6

// Reset values
`define APDC_REG_RST       8'h00
`define APDC_DIV_RST       8'h01
`define APDC_ADC_OVERSAMPLING_RATIO_RST      8'h80

// Writable bit masks
`define APDC_THUMP_MASK    8'hFC
`define APDC_FCHG_MASK     8'h3F
`define APDC_DCCTL_MASK    8'h7F
`define APDC_DIV_MASK      8'h7F
`define APDC_FILT_MASK     8'h03

// Field positions
`define APDC_ADP_SWAP      0
`define APDC_ADP_FLAG      1
`define APDC_ADP_EN        2
`define APDC_PH_LEFT       7
`define APDC_PH_MID_HI     6
`define APDC_PH_MID_LO     5
`define APDC_PH_FINE_HI    4
`define APDC_DC_EN_L       7
`define APDC_DC_EN_R       6
`define APDC_DC_MODE       5
`define APDC_DC_LEN_HI     4
`define APDC_DCC_LATCH     6
`define APDC_DCC_PRST      5
`define APDC_DCC_EXP_HI    4
`define APDC_THUMP_LO      2
`define APDC_THUMP_HI      7
`define APDC_FCHG_HI       5
`define APDC_FILT_HI       1

// Divider code zero selects the largest ratio
`define APDC_DIV_ZERO      8'h80
`define APDC_ADC_OVERSAMPLING_RATIO_ZERO     9'h100
`define APDC_DC_LEN_MAX    5'h14
`define APDC_DC_FRAC_EXT   20
`define APDC_PD_SLOTS      4

`endif

//--- src/apdc_pkg.sv
`default_nettype none
package apdc_pkg;
   typedef enum logic [1:0] {
      APDC_FILT_A = 2'b00,
      APDC_FILT_B = 2'b01,
      APDC_FILT_C = 2'b10
   } apdc_filt_t;

   typedef enum logic {
      APDC_DC_AVG = 1'b0,
      APDC_DC_IIR = 1'b1
   } apdc_dcmode_t;
endpackage
`default_nettype wire

//--- src/apdc_dc_if.sv
`default_nettype none
interface apdc_dc_if;
   logic                  mod_tick;
   apdc_pkg::apdc_dcmode_t mode;
   logic [4:0]            len;
   logic                  prst_en;
   logic [4:0]            prst_exp;

   modport src (output mod_tick, output mode, output len, output prst_en, output prst_exp);
   modport flt (input mod_tick, input mode, input len, input prst_en, input prst_exp);
endinterface
`default_nettype wire

//--- src/apdc_dc_filter.sv
`include "apdc_defs.svh"
`default_nettype none
module apdc_dc_filter #(
   parameter int IN_W = 32,
   parameter int DC_W = 24
) (
   // Clock and reset
   input  wire logic            mclk,
   input  wire logic            sys_rst,
   input  wire logic            clk_en,
   // Configuration
   apdc_dc_if.flt               cfg,
   // Sample stream
   input  wire logic            enable,
   input  wire logic            sample_valid,
   input  wire logic [IN_W-1:0] sample,
   // Result, 2.22 format
   output logic      [DC_W-1:0] result
);
   localparam int FR    = `APDC_DC_FRAC_EXT;
   localparam int ACC_W = DC_W + FR + 1;

   if (IN_W < DC_W || DC_W < 2) begin : g_bad_width
      $error("apdc_dc_filter: IN_W must be at least DC_W");
   end

   logic signed [DC_W-1:0]  x;
   logic signed [ACC_W-1:0] xe;
   logic signed [ACC_W-1:0] xs;
   logic signed [ACC_W-1:0] acc_q;
   logic signed [ACC_W-1:0] avg_sum;
   logic signed [ACC_W-1:0] avg_res;
   logic signed [ACC_W-1:0] iir_next;
   logic signed [ACC_W-1:0] iir_res;
   logic        [FR:0]      cnt_q;
   logic        [31:0]      rst_cnt_q;
   logic        [4:0]       len_v;
   logic                    cnt_last;
   logic                    prst_hit;
   logic        [DC_W-1:0]  result_q;

   assign len_v    = (cfg.len == 5'h00) ? 5'h01 :
                     (cfg.len > `APDC_DC_LEN_MAX) ? `APDC_DC_LEN_MAX : cfg.len;
   assign x        = sample[IN_W-1 -: DC_W];
   assign xe       = {{(ACC_W-DC_W){x[DC_W-1]}}, x};
   assign xs       = xe <<< FR;
   assign avg_sum  = acc_q + xe;
   assign avg_res  = avg_sum >>> len_v;
   assign iir_next = acc_q + ((xs - acc_q) >>> len_v);
   assign iir_res  = iir_next >>> FR;
   // Averaging over 2^D samples keeps the divide a plain shift
   assign cnt_last = cnt_q == ((21'h000001 << len_v) - 21'h000001);
   assign prst_hit = cfg.prst_en && cfg.mod_tick &&
                     ({1'b0, rst_cnt_q} == ((33'h000000001 << cfg.prst_exp) - 33'h000000001));
   assign result   = result_q;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rst_cnt_q <= 32'h0000_0000;
      end else if (clk_en) begin
         if (!cfg.prst_en || !enable || prst_hit) begin
            rst_cnt_q <= 32'h0000_0000;
         end else if (cfg.mod_tick) begin
            rst_cnt_q <= rst_cnt_q + 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         acc_q    <= '0;
         cnt_q    <= '0;
         result_q <= '0;
      end else if (clk_en) begin
         if (!enable) begin
            acc_q <= '0;
            cnt_q <= '0;
         end else if (cfg.mode == apdc_pkg::APDC_DC_IIR) begin
            if (sample_valid) begin
               acc_q    <= iir_next;
               result_q <= iir_res[DC_W-1:0];
            end
         end else if (prst_hit) begin
            acc_q <= '0;
            cnt_q <= '0;
         end else if (sample_valid) begin
            if (cnt_last) begin
               result_q <= avg_res[DC_W-1:0];
               acc_q    <= '0;
               cnt_q    <= '0;
            end else begin
               acc_q <= avg_sum;
               cnt_q <= cnt_q + 21'h000001;
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- verif/apdc_top_chk.sv
`default_nettype none
module apdc_top_chk (
   // Watched ports
   input wire logic        mclk,
   input wire logic        sys_rst,
   input wire logic        clk_en,
   input wire logic [9:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        adc_running,
   input wire logic        adc_modulator_clock_en,
   input wire logic        adc_sample_rate_tick,
   input wire logic        coef_bank,
   input wire logic [5:0]  anti_thump_en,
   input wire logic [5:0]  fast_charge_mode
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   wire logic       req = avs_read | avs_write;
   wire logic [7:0] idx = avs_address[9:2];
   wire logic       wdone = avs_write & ~avs_waitrequest;
   property p_first_wait; $rose(req) && clk_en |-> avs_waitrequest; endproperty
   property p_one_wait; req && avs_waitrequest && clk_en |=> !avs_waitrequest; endproperty
   property p_idle; !req |-> !avs_waitrequest; endproperty
   property p_tick; adc_sample_rate_tick |-> adc_modulator_clock_en; endproperty
   property p_thump; !$stable(anti_thump_en) |-> $past(wdone && idx == 8'h3A); endproperty
   property p_fchg; !$stable(fast_charge_mode) |-> $past(wdone && idx == 8'h47); endproperty
   property p_bank; !$stable(coef_bank) |-> $past(adc_sample_rate_tick && adc_running); endproperty
   property p_unmapped;
      avs_read && !avs_waitrequest && idx > 8'h01 && idx < 8'h3A |-> avs_readdata == 32'h0;
   endproperty
   a_first_wait: assert property (p_first_wait) else $error("no wait in first cycle");
   a_one_wait: assert property (p_one_wait) else $error("wait longer than one cycle");
   a_idle: assert property (p_idle) else $error("wait without request");
   a_tick: assert property (p_tick) else $error("sample tick off modulator pulse");
   a_thump: assert property (p_thump) else $error("anti-thump changed unwritten");
   a_fchg: assert property (p_fchg) else $error("fast-charge changed unwritten");
   a_bank: assert property (p_bank) else $error("bank flag moved off sample start");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   c_swap: cover property (!$stable(coef_bank));
   c_read: cover property (avs_read && !avs_waitrequest);
   c_write: cover property (wdone && idx == 8'h3A);
endmodule
bind apdc_top apdc_top_chk i_chk (.mclk, .sys_rst, .clk_en, .avs_address, .avs_read,
   .avs_write, .avs_readdata, .avs_waitrequest, .adc_running, .adc_modulator_clock_en,
   .adc_sample_rate_tick, .coef_bank, .anti_thump_en, .fast_charge_mode);
`default_nettype wire

//--- verif/adc_phase_dcmeas_coeff_buffer_bench.sv
`default_nettype none
module adc_phase_dcmeas_coeff_buffer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 0, sys_rst = 1, clk_en = 1, avs_read = 0, avs_write = 0, adc_running = 0;
   logic [9:0]  avs_address = 0;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [5:0]  coef_rd_addr = 0, anti_thump_en, fast_charge_mode;
   logic [31:0] avs_writedata = 0, adc_left_in = 4458, adc_right_in = 0, avs_readdata;
   logic [31:0] left_out, right_out;
   logic        avs_waitrequest, left_out_valid, right_out_valid, coef_bank;
   logic        adc_modulator_clock_en, adc_sample_rate_tick, mon_on = 0, hold = 0;
   logic [23:0] coef_rd_data;
   logic [15:0] rnd = 16'd4458;
   logic [63:0] rdq[$], lq[$], rq[$];
   logic [23:0] tb[8] = '{24'h0200_00, 24'h3A00FC, 24'h47003F, 24'h5500FF, 24'h6600FF,
                          24'h67007F, 24'h700100, 24'h728000};
   logic [7:0]  dv[8];
   int          err_count = 0, comparisons = 0, cyc = 0, i, tr, t0 = 0;
   apdc_top i_dut (.mclk, .sys_rst, .clk_en, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .adc_running,
      .adc_left_in, .adc_right_in, .adc_modulator_clock_en, .adc_sample_rate_tick,
      .left_out, .left_out_valid, .right_out, .right_out_valid, .coef_rd_addr,
      .coef_rd_data, .coef_bank, .anti_thump_en, .fast_charge_mode);
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
      comparisons++;
      if (s !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] ix, input logic [31:0] d);
      @(posedge mclk);
      {avs_read, avs_write, avs_address, avs_writedata} <= {!wr, wr, ix, 2'b00, d};
      do @(posedge mclk);
      while (avs_waitrequest);
      {avs_read, avs_write} <= 2'b00;
   endtask
   task automatic rd(input logic [7:0] ix, input logic [31:0] e);
      rdq.push_back(e);
      bus(1'b0, ix, 32'h0);
   endtask
   task automatic summarize;
      if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial forever #2.5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (!hold) adc_left_in <= {adc_left_in[15:0], lfsr(adc_left_in[15:0])};
      adc_right_in <= ~adc_left_in;
   end
   // Read data is taken at the edge where waitrequest is seen low
   always @(posedge mclk) begin
      if (avs_read && !avs_waitrequest) chk("readdata", avs_readdata, rdq.pop_front());
   end
   // Samples loaded before t0 still drain and are not judged
   always @(negedge mclk) begin
      if (mon_on && adc_sample_rate_tick) begin
         lq.push_back({cyc + 3, adc_left_in});
         rq.push_back({cyc + 2 + tr, adc_right_in});
      end
      if (left_out_valid && lq.size() > 0 && cyc >= t0 + 3)
         chk("left", {cyc, left_out}, lq.pop_front());
      if (right_out_valid && rq.size() > 0 && cyc >= t0 + 2 + tr)
         chk("right", {cyc, right_out}, rq.pop_front());
   end
   initial begin
      repeat (20000) @(posedge mclk);
      err_count++;
      summarize();
   end
   initial begin
      repeat (8) @(posedge mclk);
      sys_rst <= 0;
      rd(8'h01, 0);
      foreach (tb[k]) begin
         rnd = lfsr(rnd);
         dv[k] = rnd[7:0];
         rd(tb[k][23:16], tb[k][15:8]);
         if (tb[k][23:16] < 8'h70) bus(1, tb[k][23:16], dv[k]);
         rd(tb[k][23:16], tb[k][23:16] < 8'h70 ? dv[k] & tb[k][7:0] : tb[k][15:8]);
      end
      chk("thump", anti_thump_en, dv[1][7:2]);
      chk("fchg", fast_charge_mode, dv[2][5:0]);
      bus(1, 8'h55, 32'hA5);
      bus(1, 8'h72, 32'h20);
      for (i = 0; i < 3; i++) begin
         bus(1, 8'h73, i);
         tr = 5 + (i == 0 ? 8 : i == 1 ? 16 : 32);
         repeat (150) @(posedge mclk);
         mon_on <= 1;
         t0 = cyc + 1;
         repeat (200) @(posedge mclk);
         mon_on <= 0;
         repeat (100) @(posedge mclk);
         chk("pending", lq.size() + rq.size(), 0);
      end
      hold <= 1;
      bus(1, 8'h67, 0);
      bus(1, 8'h66, 0);
      bus(1, 8'h66, 32'hC0);
      repeat (200) @(posedge mclk);
      bus(1, 8'h67, 32'h40);
      for (i = 0; i < 3; i++) begin
         rd(8'(8'h68 + i), adc_left_in[31 - 8 * i -: 8]);
         rd(8'(8'h6B + i), adc_right_in[31 - 8 * i -: 8]);
      end
      bus(1, 8'h80, 32'h12345);
      bus(1, 8'hC0, 32'h6789A);
      rd(8'h80, 32'h12345);
      rd(8'hC0, 32'h6789A);
      adc_running <= 1;
      rd(8'h80, 0);
      bus(1, 8'h01, 4);
      bus(1, 8'h80, 32'hBCDEF);
      rd(8'hC0, 32'hBCDEF);
      rd(8'h80, 32'h12345);
      bus(1, 8'h01, 5);
      for (i = 0; i < 300 && coef_bank !== 1'b1; i++) @(posedge mclk);
      rd(8'h01, 6);
      chk("coef", coef_rd_data, 24'hBCDEF);
      repeat (4) @(posedge mclk);
      summarize();
   end
endmodule
`default_nettype wire
